// File: core/ses_pkg.sv
// Package of constants and types for the screen edit sequencer
package ses_pkg;

  // ----------------------------------------------------------------
  // Geometry and codes
  // ----------------------------------------------------------------
  localparam logic [6:0] COL_LAST   = 7'h49;   // Column 73
  localparam logic [4:0] ROW_LAST   = 5'h1A;   // Row 26
  localparam logic [6:0] COL_HOME   = 7'h00;
  localparam logic [4:0] ROW_HOME   = 5'h00;
  localparam logic [7:0] BLANK_CODE = 8'h00;
  localparam logic [7:0] EOT_MASK   = 8'hC0;   // Bits 6 and 7
  localparam int         FG_BIT     = 5;       // Unprotected flag position in a character

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] CURSOR_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] BREG_OFS   = 12'h00C;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SES_R_NONE = 2'b00,
    SES_R_DEL  = 2'b01,
    SES_R_TRANSMIT_COMMAND = 2'b10,
    SES_R_TAB  = 2'b11
  } ses_routine_t;

  typedef enum logic [2:0] {
    SES_S_IDLE = 3'b000, SES_S_1 = 3'b001, SES_S_2 = 3'b010, SES_S_3 = 3'b011,
    SES_S_4    = 3'b100, SES_S_5 = 3'b101, SES_S_6 = 3'b110, SES_S_7 = 3'b111
  } ses_step_t;

  // Memory command to the character memory logic
  typedef struct packed {
    logic       rr;        // Read/restore
    logic       cw;        // Character write
    logic [7:0] wdata;
  } ses_mem_cmd_t;

  // Phased memory cycle timing
  typedef struct packed {
    logic t06;             // Same bit order as the phase pins
    logic t03;
    logic t01;
  } ses_phase_t;

endpackage

// File: core/ses_seq.sv
// Screen edit sequencer: delete tail, transmit and tab routines with APB registers
// Summary of operation
// - Protected at cursor: restore cursor, stop.
// - Foreground at cursor: blank it, step four.
// - At 73/26 or with shift off restore and stop, else shift.
// - Step five: column up t0.3, read t0.6.
// - Step six: column down, copy A to B.
// - Step six writes A if foreground, else blank.
// - Step seven: back to three, advance, read.
// - Transmit step two writes bits 6,7 of B.
// - First step sets the skip-refresh flip-flop.
// - Transmit step three only passes.
// - Transmit step four: at home, request send.
// - Step five back and read; six tests marker.
// - Step seven: next row, column zero, send.
// - After send request the sequencer stops.
// - Tab stop is first foreground after background.
// - Tab loops read/advance over foreground chars.
// - Tab at 73/26 without entry ends there.
// - Tab step four reads, five only passes.
// - Tab six/seven continue background search.
`timescale 1ns/1ns
module ses_seq (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [2:0]           phase_pins,
  input  wire logic [7:0]           mem_rdata,
  input  wire logic                 transmit_key,
  input  wire logic                 transmit_command,
  input  wire logic                 send_done,
  output ses_pkg::ses_mem_cmd_t     mem_cmd,
  output logic                      skip_refresh,
  output logic                      begin_send_request,
  output logic      [6:0]           cursor_column_counter,
  output logic      [4:0]           cursor_row_counter
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_reg, sync2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {send_done, transmit_command, transmit_key, phase_pins};
      sync2_reg <= sync1_reg;
    end
  end
  // Timing phases are treated as one-cycle markers once synchronised
  logic [2:0] ph_last_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_last_reg <= 3'h0;
    else ph_last_reg <= sync2_reg[2:0];
  end
  ses_pkg::ses_phase_t ph;
  assign ph = sync2_reg[2:0] & ~ph_last_reg;
  logic transmit_command_rise_reg, transmit_command_in;
  assign transmit_command_in = sync2_reg[3] | sync2_reg[4];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) transmit_command_rise_reg <= 1'b0;
    else transmit_command_rise_reg <= transmit_command_in;
  end
  logic send_done_s;
  assign send_done_s = sync2_reg[5];
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ses_pkg::ses_step_t    sequencer_step;
  ses_pkg::ses_routine_t routine_reg;
  logic [6:0] saved_col_reg;             // saved_cursor_counter, column half
  logic [4:0] saved_row_reg;
  logic [7:0] a_reg;
  logic [7:0] b_reg;
  logic       unprotected_flag;          // Foreground bit of last read
  logic       eot_seen;
  logic       sending_reg;
  logic       shift_mode_reg;            // Shift-left condition from software
  logic       entry_pending_reg;         // Alphanumeric entry pending for tab
  logic       start_reg;
  ses_pkg::ses_routine_t start_kind_reg;
  logic at_end, at_home, cycle_end;
  assign at_end  = (cursor_column_counter == ses_pkg::COL_LAST) &&
                   (cursor_row_counter == ses_pkg::ROW_LAST);
  assign at_home = (cursor_column_counter == ses_pkg::COL_HOME) &&
                   (cursor_row_counter == ses_pkg::ROW_HOME);
  assign cycle_end = ph.t06;
  assign unprotected_flag = a_reg[ses_pkg::FG_BIT];
  assign eot_seen = ((a_reg & ses_pkg::EOT_MASK) == ses_pkg::EOT_MASK);
  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic apb_wr;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_mode_reg    <= 1'b0;
      entry_pending_reg <= 1'b0;
      start_reg         <= 1'b0;
      start_kind_reg    <= ses_pkg::SES_R_NONE;
    end else begin
      start_reg <= 1'b0;
      if (apb_wr && paddr == ses_pkg::CTRL_OFS) begin
        shift_mode_reg    <= pwdata[4];
        entry_pending_reg <= pwdata[5];
        start_reg         <= pwdata[1:0] != 2'b00;
        start_kind_reg    <= ses_pkg::ses_routine_t'(pwdata[1:0]);
      end else if (transmit_command_in && !transmit_command_rise_reg) begin
        start_reg      <= 1'b1;
        start_kind_reg <= ses_pkg::SES_R_TRANSMIT_COMMAND;
      end
    end
  end
  // Read data is registered so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= ses_pkg::RESET_WORD;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      if (paddr == ses_pkg::CTRL_OFS) begin
        prdata <= {26'h000_0000, entry_pending_reg, shift_mode_reg, 4'h0};
      end else if (paddr == ses_pkg::CURSOR_OFS) begin
        prdata <= {3'h0, saved_row_reg, 1'b0, saved_col_reg,
                   3'h0, cursor_row_counter, 1'b0, cursor_column_counter};
      end else if (paddr == ses_pkg::STATUS_OFS) begin
        prdata <= {24'h00_0000, sending_reg, skip_refresh, routine_reg,
                   1'b0, sequencer_step};
      end else if (paddr == ses_pkg::BREG_OFS) begin
        prdata <= {16'h0000, a_reg, b_reg};
      end else begin
        prdata  <= ses_pkg::RESET_WORD;
        pslverr <= 1'b1;                                   // Unmapped address
      end
    end
  end

  // ----------------------------------------------------------------
  // Step counter: after start moves at the end of a memory cycle, or on t0.1 at a protected delete stop
  // ----------------------------------------------------------------
  logic busy;
  assign busy = (sequencer_step != ses_pkg::SES_S_IDLE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sequencer_step <= ses_pkg::SES_S_IDLE;
      routine_reg    <= ses_pkg::SES_R_NONE;
    end else if (!busy) begin
      if (start_reg && !sending_reg) begin
        sequencer_step <= ses_pkg::SES_S_1;
        routine_reg    <= start_kind_reg;
      end
    end else if (ph.t01 && routine_reg == ses_pkg::SES_R_DEL &&
                 sequencer_step == ses_pkg::SES_S_3 && !unprotected_flag) begin
      sequencer_step <= ses_pkg::SES_S_IDLE;
    end else if (cycle_end) begin
      case (routine_reg)
        ses_pkg::SES_R_DEL: begin
          case (sequencer_step)
            ses_pkg::SES_S_3: sequencer_step <= ses_pkg::SES_S_4;
            ses_pkg::SES_S_4: begin
              if (at_end || !shift_mode_reg) sequencer_step <= ses_pkg::SES_S_IDLE;
              else sequencer_step <= ses_pkg::SES_S_5;
            end
            ses_pkg::SES_S_7: sequencer_step <= ses_pkg::SES_S_3;
            default: sequencer_step <= ses_pkg::ses_step_t'(sequencer_step + 3'd1);
          endcase
        end
        ses_pkg::SES_R_TRANSMIT_COMMAND: begin
          case (sequencer_step)
            ses_pkg::SES_S_3: sequencer_step <= ses_pkg::SES_S_4;
            ses_pkg::SES_S_4: begin
              if (at_home) sequencer_step <= ses_pkg::SES_S_IDLE;
              else sequencer_step <= ses_pkg::SES_S_5;
            end
            ses_pkg::SES_S_6: begin
              if (eot_seen) sequencer_step <= ses_pkg::SES_S_7;
              else sequencer_step <= ses_pkg::SES_S_4;
            end
            ses_pkg::SES_S_7: sequencer_step <= ses_pkg::SES_S_IDLE;
            default: sequencer_step <= ses_pkg::ses_step_t'(sequencer_step + 3'd1);
          endcase
        end
        ses_pkg::SES_R_TAB: begin
          case (sequencer_step)
            ses_pkg::SES_S_3: begin
              if (at_end && !entry_pending_reg) sequencer_step <= ses_pkg::SES_S_IDLE;
              else if (unprotected_flag) sequencer_step <= ses_pkg::SES_S_2;
              else sequencer_step <= ses_pkg::SES_S_4;
            end
            ses_pkg::SES_S_6: begin
              if (!unprotected_flag && !at_end) sequencer_step <= ses_pkg::SES_S_7;
              else sequencer_step <= ses_pkg::SES_S_IDLE;
            end
            ses_pkg::SES_S_7: sequencer_step <= ses_pkg::SES_S_4;
            default: sequencer_step <= ses_pkg::ses_step_t'(sequencer_step + 3'd1);
          endcase
        end
        default: sequencer_step <= ses_pkg::SES_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Skip-refresh flip-flop: held for the whole routine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) skip_refresh <= 1'b0;
    else if (sequencer_step == ses_pkg::SES_S_1) skip_refresh <= 1'b1;
    else if (!busy) skip_refresh <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Cursor counters: step, carry into row, restore and column clear
  // ----------------------------------------------------------------
  logic cursor_count_pulse, count_up, count_down, restore, column_clear;
  always_comb begin
    count_up = 1'b0;
    count_down = 1'b0;
    restore = 1'b0;
    column_clear = 1'b0;
    case (routine_reg)
      ses_pkg::SES_R_DEL: begin
        count_up   = ph.t03 && (sequencer_step == ses_pkg::SES_S_5 ||
                                sequencer_step == ses_pkg::SES_S_7);
        count_down = ph.t03 && sequencer_step == ses_pkg::SES_S_6;
        // Restore waits for the last blank write so that it lands at the old cursor
        restore    = (ph.t01 && sequencer_step == ses_pkg::SES_S_3 && !unprotected_flag) ||
                     (mem_cmd.cw && !busy);
      end
      ses_pkg::SES_R_TRANSMIT_COMMAND: begin
        count_down   = ph.t03 && sequencer_step == ses_pkg::SES_S_5;
        column_clear = ph.t03 && sequencer_step == ses_pkg::SES_S_7;
      end
      ses_pkg::SES_R_TAB: begin
        count_up = ph.t03 && !at_end && ((sequencer_step == ses_pkg::SES_S_3 &&
                   unprotected_flag) || sequencer_step == ses_pkg::SES_S_7);
      end
      default: ;
    endcase
    cursor_count_pulse = count_up | count_down;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cursor_column_counter <= ses_pkg::COL_HOME;
      cursor_row_counter    <= ses_pkg::ROW_HOME;
    end else if (restore) begin
      cursor_column_counter <= saved_col_reg;
      cursor_row_counter    <= saved_row_reg;
    end else if (apb_wr && paddr == ses_pkg::CURSOR_OFS && !busy) begin
      cursor_column_counter <= pwdata[6:0];                            // Placed only while idle
      cursor_row_counter    <= pwdata[12:8];
    end else if (column_clear) begin
      cursor_column_counter <= ses_pkg::COL_HOME;
      cursor_row_counter    <= cursor_row_counter + 5'd1;
    end else if (cursor_count_pulse && count_up) begin
      if (cursor_column_counter == ses_pkg::COL_LAST) begin
        cursor_column_counter <= ses_pkg::COL_HOME;
        cursor_row_counter    <= cursor_row_counter + 5'd1;
      end else begin
        cursor_column_counter <= cursor_column_counter + 7'd1;
      end
    end else if (cursor_count_pulse) begin
      if (cursor_column_counter == ses_pkg::COL_HOME) begin
        cursor_column_counter <= ses_pkg::COL_LAST;
        cursor_row_counter    <= cursor_row_counter - 5'd1;
      end else begin
        cursor_column_counter <= cursor_column_counter - 7'd1;
      end
    end
  end
  // Saved cursor is loaded when a routine starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_col_reg <= ses_pkg::COL_HOME;
      saved_row_reg <= ses_pkg::ROW_HOME;
    end else if (sequencer_step == ses_pkg::SES_S_1) begin
      saved_col_reg <= cursor_column_counter;
      saved_row_reg <= cursor_row_counter;
    end
  end
  // ----------------------------------------------------------------
  // Memory commands, all issued on t0.6
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_cmd <= '0;
    end else begin
      mem_cmd <= '0;
      if (ph.t06) begin
        case (routine_reg)
          ses_pkg::SES_R_DEL: begin
            if (sequencer_step == ses_pkg::SES_S_2 || sequencer_step == ses_pkg::SES_S_5 ||
                sequencer_step == ses_pkg::SES_S_7)
              mem_cmd.rr <= 1'b1;
            if (sequencer_step == ses_pkg::SES_S_4) begin
              mem_cmd.cw    <= 1'b1;
              mem_cmd.wdata <= ses_pkg::BLANK_CODE;
            end
            if (sequencer_step == ses_pkg::SES_S_6) begin
              mem_cmd.cw    <= 1'b1;
              mem_cmd.wdata <= unprotected_flag ? a_reg : ses_pkg::BLANK_CODE;
            end
          end
          ses_pkg::SES_R_TRANSMIT_COMMAND: begin
            if (sequencer_step == ses_pkg::SES_S_2) begin
              mem_cmd.cw    <= 1'b1;
              mem_cmd.wdata <= b_reg & ses_pkg::EOT_MASK;
            end
            if (sequencer_step == ses_pkg::SES_S_5) mem_cmd.rr <= 1'b1;
          end
          ses_pkg::SES_R_TAB: begin
            if (sequencer_step == ses_pkg::SES_S_2 || sequencer_step == ses_pkg::SES_S_4)
              mem_cmd.rr <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
  // Data registers: A captures reads, B takes A in delete step six
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_reg <= ses_pkg::BLANK_CODE;
      b_reg <= ses_pkg::EOT_MASK;
    end else begin
      if (mem_cmd.rr) a_reg <= mem_rdata;
      if (ph.t06 && routine_reg == ses_pkg::SES_R_DEL &&
          sequencer_step == ses_pkg::SES_S_6)
        b_reg <= a_reg;
    end
  end
  // ----------------------------------------------------------------
  // Send request: one pulse, then sending_reg holds off starts until the I/O logic is done
  // ----------------------------------------------------------------
  logic send_fire;
  assign send_fire = cycle_end && routine_reg == ses_pkg::SES_R_TRANSMIT_COMMAND &&
                     ((sequencer_step == ses_pkg::SES_S_4 && at_home) ||
                      sequencer_step == ses_pkg::SES_S_7);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      begin_send_request <= 1'b0;
      sending_reg        <= 1'b0;
    end else begin
      begin_send_request <= send_fire;
      if (send_fire) sending_reg <= 1'b1;
      else if (send_done_s) sending_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  step_on_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && $changed(sequencer_step) && $past(sequencer_step) != ses_pkg::SES_S_IDLE)
    |-> ($past(ph.t06) || $past(ph.t01))) else $error("step moved off phase");
  prot_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ph.t01 && routine_reg == ses_pkg::SES_R_DEL && sequencer_step == ses_pkg::SES_S_3
     && !unprotected_flag) |=> (sequencer_step == ses_pkg::SES_S_IDLE &&
     cursor_column_counter == $past(saved_col_reg))) else $error("no restore");
  blank_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ph.t06 && routine_reg == ses_pkg::SES_R_DEL && sequencer_step == ses_pkg::SES_S_4)
    |=> (mem_cmd.cw && mem_cmd.wdata == ses_pkg::BLANK_CODE)) else $error("no blank");
  b_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ph.t06 && routine_reg == ses_pkg::SES_R_DEL && sequencer_step == ses_pkg::SES_S_6)
    |=> b_reg == $past(a_reg)) else $error("B not loaded");
  eot_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ph.t06 && routine_reg == ses_pkg::SES_R_TRANSMIT_COMMAND && sequencer_step == ses_pkg::SES_S_2)
    |=> (mem_cmd.cw && mem_cmd.wdata == ($past(b_reg) & ses_pkg::EOT_MASK)))
    else $error("marker not written");
  skip_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sequencer_step == ses_pkg::SES_S_1) |=> skip_refresh) else $error("skip refresh");
  home_send_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cycle_end && routine_reg == ses_pkg::SES_R_TRANSMIT_COMMAND && sequencer_step == ses_pkg::SES_S_4
     && at_home) |=> (begin_send_request && !busy)) else $error("home send");
  row_next_a: assert property (@(posedge pclk) disable iff (!presetn)
    column_clear |=> (cursor_column_counter == ses_pkg::COL_HOME &&
    cursor_row_counter == $past(cursor_row_counter) + 5'd1)) else $error("next row");
  tab_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cycle_end && routine_reg == ses_pkg::SES_R_TAB && sequencer_step == ses_pkg::SES_S_3
     && at_end && !entry_pending_reg) |=> !busy) else $error("tab end");
  del_loop_c: cover property (@(posedge pclk) disable iff (!presetn)
    routine_reg == ses_pkg::SES_R_DEL && sequencer_step == ses_pkg::SES_S_7);
  transmit_command_eot_c: cover property (@(posedge pclk) disable iff (!presetn)
    routine_reg == ses_pkg::SES_R_TRANSMIT_COMMAND && sequencer_step == ses_pkg::SES_S_7);
  tab_bg_c: cover property (@(posedge pclk) disable iff (!presetn)
    routine_reg == ses_pkg::SES_R_TAB && sequencer_step == ses_pkg::SES_S_7);

endmodule

// File: sim/ses_mem_model.sv
// Partner model: character memory, memory cycle timing and send logic
`timescale 1ns/1ns
module ses_mem_model (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire ses_pkg::ses_mem_cmd_t mem_cmd,
  input  wire logic [6:0]            col,
  input  wire logic [4:0]            row,
  input  wire logic                  begin_send_request,
  output logic      [2:0]            phase_pins,
  output logic      [7:0]            mem_rdata,
  output logic                       send_done
);
  logic [7:0] mem [0:4095];
  logic [7:0] idle_q = 8'h5A;
  logic [2:0] ph;
  logic [3:0] snd;
  // Six-clock memory cycle, each phase high one clock so every edge is seen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph         <= 3'h0;
      phase_pins <= 3'h0;
      snd        <= 4'h0;
      send_done  <= 1'b0;
    end else begin
      ph         <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      phase_pins <= {ph == 3'h4, ph == 3'h2, ph == 3'h0};
      snd        <= begin_send_request ? 4'hf : snd - 4'(snd != 4'h0);
      send_done  <= snd != 4'h0 && snd < 4'h4;
    end
  end
  // Read data stands while the read strobe is high, as the sequencer takes it then;
  // between reads the line toggles so a stale read is never mistaken for a character
  assign mem_rdata = mem_cmd.rr ? mem[{row, col}] : idle_q;
  always @(posedge pclk) begin
    idle_q <= ~idle_q;
    if (mem_cmd.cw)
      mem[{row, col}] <= mem_cmd.wdata;
  end
endmodule

// File: sim/ses_seq_tb_top.sv
// Self-checking bench for the screen edit sequencer
`timescale 1ns/1ns
module ses_seq_tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tkey = 1'b0, tcmd = 1'b0, pready, pslverr, skip_refresh, sk_q, e;
  logic        begin_send_request, send_done;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r, seed = 32'he2ac;
  logic [6:0]  col;
  logic [4:0]  row;
  logic [2:0]  phase_pins;
  logic [7:0]  mem_rdata;
  logic [11:0] exp_q[$];
  int          bad_count = 0, n_compared = 0, n_done = 0, n_send = 0;
  ses_pkg::ses_mem_cmd_t mem_cmd;
  ses_seq i_ses_seq (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_pins(phase_pins), .mem_rdata(mem_rdata), .transmit_key(tkey),
    .transmit_command(tcmd), .send_done(send_done), .mem_cmd(mem_cmd),
    .skip_refresh(skip_refresh), .begin_send_request(begin_send_request),
    .cursor_column_counter(col), .cursor_row_counter(row));
  ses_mem_model i_ses_mem_model (.pclk(pclk), .presetn(presetn), .mem_cmd(mem_cmd),
    .col(col), .row(row), .begin_send_request(begin_send_request),
    .phase_pins(phase_pins), .mem_rdata(mem_rdata), .send_done(send_done));
  // 25 MHz clock
  always #20 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic clr();
    for (int j = 0; j < 4096; j++) i_ses_mem_model.mem[j] = 8'h00;
  endtask
  // One APB transfer; result left in r and e
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      bad_count++;
      close_out();
    end
  endtask
  // Start a routine, note the expected cursor, wait for the end and for sending to clear
  task automatic go(input logic [1:0] how, input logic [31:0] ctrl, input logic [11:0] want);
    int k, t;
    k = n_done;
    exp_q.push_back(want);
    if (how == 2'd1) tkey <= 1'b1;
    else if (how == 2'd2) tcmd <= 1'b1;
    else apb(ses_pkg::CTRL_OFS, 1'b1, ctrl);
    for (t = 0; t < 70000 && n_done == k; t++) @(posedge pclk);
    tkey <= 1'b0;
    tcmd <= 1'b0;
    for (t = 0; t < 20; t++) begin
      apb(ses_pkg::STATUS_OFS, 1'b0, 32'h0);
      if (r[7] === 1'b0) break;
    end
    if (n_done == k || t == 20) begin
      bad_count++;
      close_out();
    end
  endtask
  // Results appear when the routine drops its refresh request
  always @(posedge pclk) begin
    sk_q <= skip_refresh;
    if (begin_send_request === 1'b1) n_send++;
    if (sk_q === 1'b1 && skip_refresh === 1'b0) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({row, col}, exp_q.pop_front());
      n_done++;
    end
  end
  initial begin
    int i, mr;
    logic [6:0] c;
    logic [4:0] y;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h010, 1'b0, 32'h0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    // Transmit from each source: search to home, then back to an earlier marker
    for (i = 0; i < 3; i++) begin
      c  = 7'(xs() % 74);
      y  = 5'(1 + xs() % 4);
      mr = xs() % y;
      clr();
      if (i > 0) i_ses_mem_model.mem[{5'(mr), 7'(xs() % 74)}] = ses_pkg::EOT_MASK;
      apb(ses_pkg::CURSOR_OFS, 1'b1, {19'h0, y, 1'b0, c});
      go(2'(i), 32'h2, (i == 0) ? 12'h000 : {5'(mr + 1), 7'h00});
      check(i_ses_mem_model.mem[{y, c}], ses_pkg::EOT_MASK);
      check(n_send, i + 1);
    end
    // Tab over a foreground then a background field, then a screen with no stop
    clr();
    for (i = 0; i < 3; i++) i_ses_mem_model.mem[i] = 8'h20;
    i_ses_mem_model.mem[6] = 8'h21;
    apb(ses_pkg::CURSOR_OFS, 1'b1, 32'h0);
    go(2'd0, 32'h3, 12'h006);
    clr();
    apb(ses_pkg::CURSOR_OFS, 1'b1, 32'h0);
    go(2'd0, 32'h3, {ses_pkg::ROW_LAST, ses_pkg::COL_LAST});
    apb(ses_pkg::CURSOR_OFS, 1'b0, 32'h0);
    check(r, {19'h0, ses_pkg::ROW_LAST, 1'b0, ses_pkg::COL_LAST});
    // Delete: stop at a protected cell leaves the run untouched, then a foreground run shifted left
    clr();
    for (i = 2; i < 5; i++) i_ses_mem_model.mem[i] = 8'(8'h1F + i);
    apb(ses_pkg::CURSOR_OFS, 1'b1, 32'h5);
    go(2'd0, 32'h11, 12'h005);
    check(i_ses_mem_model.mem[2], 8'h21);
    apb(ses_pkg::CURSOR_OFS, 1'b1, 32'h2);
    go(2'd0, 32'h11, 12'h002);
    for (i = 2; i < 5; i++)
      check(i_ses_mem_model.mem[i], (i < 4) ? 8'(8'h20 + i) : ses_pkg::BLANK_CODE);
    close_out();
  end
endmodule
